// ---- dv/can_flags_monitor.sv ----
`timescale 1ns/1ps
module can_flags_monitor
  import can_flags_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic pready,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pslverr,
  input wire logic rx_arrive,
  input wire logic tx_done,
  input wire logic tx_abort_done,
  input wire logic store_en,
  input wire logic unread_message_flag,
  input wire logic mailbox_empty_flag,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic wr_done;
  assign wr_done = pready && pwrite;
  ////////////////////////////////////////////////////////////
  property p_wait; psel && penable && !pready |=> pready; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready && prdata == 0; endproperty
  property p_rsv; pready && !pwrite && paddr == OFF_IRQ_FLAGS |-> prdata[31:10] == 0 && prdata[7:0] == 0; endproperty
  property p_un_set; $rose(unread_message_flag) |-> $past(rx_arrive); endproperty
  property p_un_clr; $fell(unread_message_flag) |-> $past(wr_done && paddr == OFF_UNREAD); endproperty
  property p_em_set; $rose(mailbox_empty_flag) |-> $past(tx_done || tx_abort_done); endproperty
  property p_em_clr;
    $fell(mailbox_empty_flag) |-> $past(wr_done && (paddr == OFF_TX_ACK || paddr == OFF_ABORT_ACK));
  endproperty
  property p_store; store_en |-> $past(rx_arrive); endproperty
  // an unmask write may also raise it, so any register write counts
  property p_irq; $rose(irq) |-> $past(rx_arrive || tx_done || tx_abort_done || wr_done); endproperty
  ////////////////////////////////////////////////////////////
  a_wait:
    assert property (p_wait) else $error("pready late");
  a_pulse:
    assert property (p_pulse) else $error("pready held");
  a_err:
    assert property (p_err) else $error("error answer bad");
  a_rsv:
    assert property (p_rsv) else $error("flag word spare bits set");
  a_un_set:
    assert property (p_un_set) else $error("unread flag rose without arrival");
  a_un_clr:
    assert property (p_un_clr) else $error("unread flag fell without clear");
  a_em_set:
    assert property (p_em_set) else $error("empty flag rose without ack");
  a_em_clr:
    assert property (p_em_clr) else $error("empty flag fell without ack clear");
  a_store:
    assert property (p_store) else $error("store without arrival");
  a_irq:
    assert property (p_irq) else $error("irq rose without cause");
  c_over: cover property ($rose(unread_message_flag));
  c_empty: cover property ($rose(mailbox_empty_flag));
  c_err: cover property (pslverr);
endmodule : can_flags_monitor
bind can_overrun_and_mailbox_empty_flags can_flags_monitor u_mon(.clk, .nrst, .psel, .penable, .pwrite,
  .paddr, .pready, .prdata, .pslverr, .rx_arrive, .tx_done, .tx_abort_done, .store_en,
  .unread_message_flag, .mailbox_empty_flag, .irq);

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
module testbench
  import can_flags_pkg::*;
;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, e, ovw, emp;
  logic rx_arrive, rx_remote, tx_done, tx_abort_done, store_en, unread_message_flag, mailbox_empty_flag, irq;
  logic [7:0] paddr, seed;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] rx_index, tx_index, store_index;
  logic [15:0] rxp, rfp, ums, msk, txp, ack, abk;
  logic [1:0] evt, emsk;
  int error_cnt, cmp_count;
  can_overrun_and_mailbox_empty_flags u_can_overrun_and_mailbox_empty_flags(.clk, .nrst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .rx_arrive, .rx_index, .rx_remote, .tx_done,
    .tx_abort_done, .tx_index, .store_en, .store_index, .unread_message_flag, .mailbox_empty_flag, .irq);
  ////////////////////////////////////////////////////////////
  function automatic logic [7:0] nxt(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : nxt
  task automatic finish_test();
    if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task automatic chk(string n, logic [31:0] x, logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", n, x, g);
    end
  endtask : chk
  // request held until pready is seen; the watchdog bounds the wait
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite} <= {1'b1, 1'b0, w};
    {paddr, pwdata} <= {a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
  endtask : apb
  task automatic look();
    @(posedge clk);
    chk("unread", 32'(|ums), 32'(unread_message_flag));
    chk("empty", 32'(emp), 32'(mailbox_empty_flag));
    chk("irq", 32'(|(evt & ~emsk)), 32'(irq));
  endtask : look
  task automatic wr(logic [7:0] a, logic [15:0] d);
    apb(1'b1, a, {16'h0000, d});
    case (a)
      OFF_RX_PEND: rxp &= ~d;
      OFF_RF_PEND: rfp &= ~d;
      OFF_UNREAD: ums &= ~d;
      OFF_MB_MASK: msk = d;
      OFF_TX_PEND: txp |= d;
      OFF_TX_ACK: ack &= ~d;
      OFF_ABORT_ACK: abk &= ~d;
      OFF_CTRL: ovw = d[0];
      OFF_EVT_STATUS: evt &= ~d[1:0];
      OFF_EVT_MASK: emsk = d[1:0];
      default: ;
    endcase
    if ((ack | abk) == 16'h0000) emp = 1'b0;
    look();
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk("prdata", x, r);
    chk("pslverr", 32'(a > OFF_EVT_MASK), 32'(e));
  endtask : rd
  // k: 0 data frame, 1 remote frame, 2 sent, 3 aborted
  task automatic ev(int k, logic [3:0] i);
    logic st;
    st = k < 2;
    @(posedge clk);
    {rx_arrive, rx_remote, tx_done, tx_abort_done} <= {k < 2, k == 1, k == 2, k == 3};
    {rx_index, tx_index} <= {i, i};
    @(posedge clk);
    {rx_arrive, tx_done, tx_abort_done} <= 3'h0;
    if (k < 2 && (rxp[i] | rfp[i])) begin
      ums[i] = 1'b1;
      st = ovw;
      if (!msk[i]) evt[0] = 1'b1;
    end
    if (k == 0 && st) rxp[i] = 1'b1;
    if (k == 1 && st) rfp[i] = 1'b1;
    if (k > 1) begin
      txp[i] = 1'b0;
      if (k == 2) ack[i] = 1'b1;
      if (k == 3) abk[i] = 1'b1;
      if (!msk[i]) {emp, evt[1]} = 2'h3;
    end
    look();
    chk("store", 32'(st), 32'(store_en));
    if (st) chk("sidx", 32'(i), 32'(store_index));
  endtask : ev
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (4000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
  initial begin
    {psel, penable, pwrite, rx_arrive, rx_remote, tx_done, tx_abort_done, nrst} = 8'h00;
    {paddr, pwdata, rx_index, tx_index} = '0;
    {rxp, rfp, ums, msk, txp, ack, abk, evt, emsk, ovw, emp} = '0;
    {error_cnt, cmp_count} = 0;
    seed = 8'h3b;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    for (int a = 0; a < 48; a += 4) rd(8'(a), 32'h0);
    wr(OFF_IRQ_FLAGS, 16'hffff);
    rd(OFF_IRQ_FLAGS, 32'h0);
    // few mailboxes so arrivals collide often
    for (int n = 0; n < 16; n++) begin
      seed = nxt(seed);
      if (n == 4) wr(OFF_MB_MASK, 16'h0003);
      if (n == 8) wr(OFF_CTRL, 16'h0001);
      ev(int'(seed[4]), seed[3:0] & 4'h3);
    end
    rd(OFF_UNREAD, 32'(ums));
    rd(OFF_CTRL, 32'(ovw));
    wr(OFF_RX_PEND, 16'h0005);
    wr(OFF_RF_PEND, 16'h000a);
    rd(OFF_RX_PEND, 32'(rxp));
    rd(OFF_RF_PEND, 32'(rfp));
    wr(OFF_EVT_MASK, 16'h0001);
    wr(OFF_EVT_STATUS, 16'h0003);
    wr(OFF_EVT_MASK, 16'h0000);
    wr(OFF_UNREAD, 16'h0000);
    for (int i = 0; i < 4; i++) wr(OFF_UNREAD, 16'(1 << i));
    wr(OFF_MB_MASK, 16'h0040);
    wr(OFF_TX_PEND, {8'h00, seed} | 16'h00f0);
    ev(2, 4'h4);
    rd(OFF_IRQ_FLAGS, 32'({|ums, emp}) << 8);
    ev(3, 4'h5);
    rd(OFF_TX_PEND, 32'(txp));
    wr(OFF_TX_ACK, 16'h0010);
    wr(OFF_ABORT_ACK, 16'h0020);
    ev(2, 4'h6);
    wr(OFF_TX_ACK, 16'h0040);
    rd(OFF_IRQ_FLAGS, 32'({|ums, emp}) << 8);
    // raise the empty flag, then reset in mid-run: flags and model both return to zero
    ev(2, 4'h7);
    rd(OFF_EVT_STATUS, 32'(evt));
    rd(OFF_TX_ACK, 32'(ack));
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    {rxp, rfp, ums, msk, txp, ack, abk, evt, emsk, ovw, emp} = '0;
    chk("rst_unread", 32'h0, 32'(unread_message_flag));
    chk("rst_empty", 32'h0, 32'(mailbox_empty_flag));
    nrst <= 1'b1;
    look();
    rd(OFF_TX_ACK, 32'h0);
    ev(0, 4'h1);
    ev(0, 4'h1);
    rd(OFF_IRQ_FLAGS, 32'({|ums, emp}) << 8);
    finish_test();
  end
endmodule : testbench

// ---- verilog/apb_port.sv ----
`timescale 1ns/1ps
// apb slave handshake: one wait state, registered answer
module apb_port (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic addr_ok,
  input wire logic [31:0] rdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic wr_fire
);

  logic access;
  logic next_pready;
  logic [31:0] next_prdata;
  logic next_pslverr;

  always_comb begin
    access = psel & penable & ~pready;
    next_pready = access;
    next_prdata = (access && !pwrite && addr_ok) ? rdata : 32'h0000_0000;
    next_pslverr = access & ~addr_ok;
    // writes land only on the completing edge
    wr_fire = psel & penable & pready & pwrite & ~pslverr;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= next_pready;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

endmodule : apb_port

// ---- verilog/can_flags_pkg.sv ----
package can_flags_pkg;

  // mailbox count and register geometry
  localparam int MB_COUNT = 16;
  localparam int FLAGS_W = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] OFF_IRQ_FLAGS = 8'h00;
  localparam logic [7:0] OFF_RX_PEND = 8'h04;
  localparam logic [7:0] OFF_RF_PEND = 8'h08;
  localparam logic [7:0] OFF_UNREAD = 8'h0c;
  localparam logic [7:0] OFF_MB_MASK = 8'h10;
  localparam logic [7:0] OFF_TX_PEND = 8'h14;
  localparam logic [7:0] OFF_TX_ACK = 8'h18;
  localparam logic [7:0] OFF_ABORT_ACK = 8'h1c;
  localparam logic [7:0] OFF_CTRL = 8'h20;
  localparam logic [7:0] OFF_EVT_STATUS = 8'h24;
  localparam logic [7:0] OFF_EVT_MASK = 8'h28;

  // field positions
  localparam int BIT_UNREAD_FLAG = 9;
  localparam int BIT_EMPTY_FLAG = 8;
  localparam int BIT_NEW_MSG_CTRL = 0;
  localparam int EVT_UNREAD = 0;
  localparam int EVT_EMPTY = 1;
  localparam int EVT_W = 2;

  // reset values
  localparam logic [MB_COUNT-1:0] RST_MB_MASK = 16'h0000;
  localparam logic RST_NEW_MSG_CTRL = 1'b0;
  localparam logic [EVT_W-1:0] RST_EVT_MASK = 2'h0;

endpackage : can_flags_pkg

// ---- verilog/can_overrun_and_mailbox_empty_flags.sv ----
// Operation
// - any arrival on a mailbox still pending, masked or not, marks it unread and raises the unread flag
// - unread flag reads one while any per-mailbox unread status bit is set
// - unread flag drops only after every unread status bit is cleared
// - writing one clears an unread status bit; writing zero does nothing
// - arrival on a still-pending mailbox is dropped or overwrites, per new-message control
// - unread flag is bit 9, resets to zero, read-only, ignores writes
// - mailbox-empty flag sets when an unmasked transmit or abort acknowledge sets
// - mailbox-empty flag clears itself once all acknowledge bits are clear
// - mailbox-empty flag is bit 8, resets zero, one means a mailbox is free
// - mailbox-empty flag rises on the first freed mailbox, not an empty queue
// - the flag register is a 16-bit status register
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module can_overrun_and_mailbox_empty_flags
  import can_flags_pkg::*;
#(
  parameter int NUM_MB = MB_COUNT,
  localparam int IDX_W = $clog2(NUM_MB)
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic pready,
  output logic [DATA_W-1:0] prdata,
  output logic pslverr,
  input wire logic rx_arrive,
  input wire logic [IDX_W-1:0] rx_index,
  input wire logic rx_remote,
  input wire logic tx_done,
  input wire logic tx_abort_done,
  input wire logic [IDX_W-1:0] tx_index,
  output logic store_en,
  output logic [IDX_W-1:0] store_index,
  output logic unread_message_flag,
  output logic mailbox_empty_flag,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  function automatic logic [DATA_W-1:0] widen(input logic [NUM_MB-1:0] v);
    widen = DATA_W'(v);
  endfunction : widen

  ////////////////////////////////////////////////////////////////////////////
  // bus slave

  logic wr_fire;
  logic addr_ok;
  logic [DATA_W-1:0] rdata;
  logic [NUM_MB-1:0] wmb;

  apb_port u_apb (
    .clk(clk),
    .nrst(nrst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .addr_ok(addr_ok),
    .rdata(rdata),
    .pready(pready),
    .prdata(prdata),
    .pslverr(pslverr),
    .wr_fire(wr_fire)
  );

  assign wmb = pwdata[NUM_MB-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // per-mailbox status

  logic [NUM_MB-1:0] rx_pend;
  logic [NUM_MB-1:0] rf_pend;
  logic [NUM_MB-1:0] unread;
  logic [NUM_MB-1:0] tx_pend;
  logic [NUM_MB-1:0] tx_ack;
  logic [NUM_MB-1:0] abort_ack;
  logic [NUM_MB-1:0] next_unread;
  logic [NUM_MB-1:0] next_tx_ack;
  logic [NUM_MB-1:0] next_abort_ack;
  logic [NUM_MB-1:0] rx_pend_set;
  logic [NUM_MB-1:0] rf_pend_set;
  logic [NUM_MB-1:0] unread_set;
  logic [NUM_MB-1:0] tx_pend_set;
  logic [NUM_MB-1:0] tx_ack_set;
  logic [NUM_MB-1:0] abort_ack_set;
  logic [NUM_MB-1:0] rx_pend_clr;
  logic [NUM_MB-1:0] rf_pend_clr;
  logic [NUM_MB-1:0] unread_clr;
  logic [NUM_MB-1:0] tx_pend_clr;
  logic [NUM_MB-1:0] tx_ack_clr;
  logic [NUM_MB-1:0] abort_ack_clr;
  logic [NUM_MB-1:0] rx_onehot;
  logic [NUM_MB-1:0] tx_onehot;
  logic [NUM_MB-1:0] mb_mask;
  logic [NUM_MB-1:0] next_mb_mask;
  logic new_message_control;
  logic next_new_message_control;
  logic busy;
  logic overrun;
  logic accept;
  logic next_store_en;
  logic [IDX_W-1:0] next_store_index;

  always_comb begin
    rx_onehot = rx_arrive ? (NUM_MB'(1) << rx_index) : '0;
    tx_onehot = NUM_MB'(1) << tx_index;
    busy = |((rx_pend | rf_pend) & rx_onehot);
    overrun = rx_arrive & busy;
    // discard keeps the old frame, overwrite stores the new one over it
    accept = rx_arrive & (~busy | new_message_control);
    unread_set = overrun ? rx_onehot : '0;
    rx_pend_set = (accept && !rx_remote) ? rx_onehot : '0;
    rf_pend_set = (accept && rx_remote) ? rx_onehot : '0;
    rx_pend_clr = (wr_fire && hit(paddr, OFF_RX_PEND)) ? wmb : '0;
    rf_pend_clr = (wr_fire && hit(paddr, OFF_RF_PEND)) ? wmb : '0;
    unread_clr = (wr_fire && hit(paddr, OFF_UNREAD)) ? wmb : '0;
    tx_pend_set = (wr_fire && hit(paddr, OFF_TX_PEND)) ? wmb : '0;
    tx_ack_set = tx_done ? tx_onehot : '0;
    abort_ack_set = tx_abort_done ? tx_onehot : '0;
    tx_pend_clr = tx_ack_set | abort_ack_set;
    tx_ack_clr = (wr_fire && hit(paddr, OFF_TX_ACK)) ? wmb : '0;
    abort_ack_clr = (wr_fire && hit(paddr, OFF_ABORT_ACK)) ? wmb : '0;
    next_store_en = accept;
    next_store_index = accept ? rx_index : store_index;
    next_mb_mask = (wr_fire && hit(paddr, OFF_MB_MASK)) ? wmb : mb_mask;
    next_new_message_control = (wr_fire && hit(paddr, OFF_CTRL)) ? pwdata[BIT_NEW_MSG_CTRL] : new_message_control;
  end

  flag_bank #(.WIDTH(NUM_MB)) u_rx_pend (
    .clk(clk),
    .nrst(nrst),
    .set_bits(rx_pend_set),
    .clear_bits(rx_pend_clr),
    .bits(rx_pend),
    .next_bits()
  );

  flag_bank #(.WIDTH(NUM_MB)) u_rf_pend (
    .clk(clk),
    .nrst(nrst),
    .set_bits(rf_pend_set),
    .clear_bits(rf_pend_clr),
    .bits(rf_pend),
    .next_bits()
  );

  flag_bank #(.WIDTH(NUM_MB)) u_unread (
    .clk(clk),
    .nrst(nrst),
    .set_bits(unread_set),
    .clear_bits(unread_clr),
    .bits(unread),
    .next_bits(next_unread)
  );

  // a new request written in the completion cycle stays pending
  flag_bank #(.WIDTH(NUM_MB)) u_tx_pend (
    .clk(clk),
    .nrst(nrst),
    .set_bits(tx_pend_set),
    .clear_bits(tx_pend_clr),
    .bits(tx_pend),
    .next_bits()
  );

  flag_bank #(.WIDTH(NUM_MB)) u_tx_ack (
    .clk(clk),
    .nrst(nrst),
    .set_bits(tx_ack_set),
    .clear_bits(tx_ack_clr),
    .bits(tx_ack),
    .next_bits(next_tx_ack)
  );

  flag_bank #(.WIDTH(NUM_MB)) u_abort_ack (
    .clk(clk),
    .nrst(nrst),
    .set_bits(abort_ack_set),
    .clear_bits(abort_ack_clr),
    .bits(abort_ack),
    .next_bits(next_abort_ack)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mb_mask <= RST_MB_MASK[NUM_MB-1:0];
      new_message_control <= RST_NEW_MSG_CTRL;
      store_en <= 1'b0;
      store_index <= '0;
    end else begin
      mb_mask <= next_mb_mask;
      new_message_control <= next_new_message_control;
      store_en <= next_store_en;
      store_index <= next_store_index;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request flags

  logic ev_unread;
  logic ev_empty;
  logic next_unread_flag;
  logic next_empty_flag;

  always_comb begin
    ev_unread = overrun & |(rx_onehot & ~mb_mask);
    // any single freed unmasked mailbox counts; the rest of the queue is irrelevant
    ev_empty = |((tx_ack_set | abort_ack_set) & ~mb_mask);
    // status bits are cleared only through the unread bank, never here
    next_unread_flag = |next_unread;
    if (ev_empty) begin
      next_empty_flag = 1'b1;
    end else if (~|(next_tx_ack | next_abort_ack)) begin
      next_empty_flag = 1'b0;
    end else begin
      next_empty_flag = mailbox_empty_flag;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      unread_message_flag <= 1'b0;
      mailbox_empty_flag <= 1'b0;
    end else begin
      unread_message_flag <= next_unread_flag;
      mailbox_empty_flag <= next_empty_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt events

  logic [EVT_W-1:0] evt_status;
  logic [EVT_W-1:0] evt_mask;
  logic [EVT_W-1:0] next_evt_status;
  logic [EVT_W-1:0] next_evt_mask;
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] evt_clr;
  logic next_irq;

  always_comb begin
    evt_set = '0;
    evt_set[EVT_UNREAD] = ev_unread;
    evt_set[EVT_EMPTY] = ev_empty;
    evt_clr = (wr_fire && hit(paddr, OFF_EVT_STATUS)) ? pwdata[EVT_W-1:0] : '0;
    // set beats clear so an event in the clearing cycle survives
    next_evt_status = evt_set | (evt_status & ~evt_clr);
    next_evt_mask = (wr_fire && hit(paddr, OFF_EVT_MASK)) ? pwdata[EVT_W-1:0] : evt_mask;
    next_irq = |(next_evt_status & ~next_evt_mask);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      evt_status <= '0;
      evt_mask <= RST_EVT_MASK;
      irq <= 1'b0;
    end else begin
      evt_status <= next_evt_status;
      evt_mask <= next_evt_mask;
      irq <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux

  logic [FLAGS_W-1:0] flags_word;

  always_comb begin
    flags_word = '0;
    flags_word[BIT_UNREAD_FLAG] = unread_message_flag;
    flags_word[BIT_EMPTY_FLAG] = mailbox_empty_flag;
    addr_ok = 1'b1;
    case (paddr)
      OFF_IRQ_FLAGS: rdata = DATA_W'(flags_word);
      OFF_RX_PEND: rdata = widen(rx_pend);
      OFF_RF_PEND: rdata = widen(rf_pend);
      OFF_UNREAD: rdata = widen(unread);
      OFF_MB_MASK: rdata = widen(mb_mask);
      OFF_TX_PEND: rdata = widen(tx_pend);
      OFF_TX_ACK: rdata = widen(tx_ack);
      OFF_ABORT_ACK: rdata = widen(abort_ack);
      OFF_CTRL: rdata = DATA_W'(new_message_control);
      OFF_EVT_STATUS: rdata = DATA_W'(evt_status);
      OFF_EVT_MASK: rdata = DATA_W'(evt_mask);
      default: begin
        rdata = '0;
        addr_ok = 1'b0;
      end
    endcase
  end

endmodule : can_overrun_and_mailbox_empty_flags

// ---- verilog/flag_bank.sv ----
`timescale 1ns/1ps
// bit vector set by one source and cleared by another; a set in the clearing cycle wins
module flag_bank #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] set_bits,
  input wire logic [WIDTH-1:0] clear_bits,
  output logic [WIDTH-1:0] bits,
  output logic [WIDTH-1:0] next_bits
);

  always_comb begin
    next_bits = set_bits | (bits & ~clear_bits);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bits <= '0;
    end else begin
      bits <= next_bits;
    end
  end

endmodule : flag_bank
